// ==== core/rmf_master_fsm.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rmf_cfg.svh"
module rmf_master_fsm
    import rmf_pkg::*;
#(
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register writes from the serial interface
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_addr,
    input wire logic [7:0] reg_wr_data,
    // Receive control bits
    input wire logic [3:0] rx_ctrl,
    input wire logic [1:0] modulation_type_cfg_a,
    input wire logic [1:0] modulation_type_cfg_b,
    input wire logic [4:0] channel_one_pll_setting_a,
    input wire logic [4:0] channel_one_pll_setting_b,
    // Receiver status
    input wire logic powerup_done,
    input wire logic sym_sync,
    input wire logic frame_start_event,
    input wire logic bit_valid,
    input wire logic bit_data,
    input wire logic id_scan_done,
    input wire logic id_scan_valid,
    input wire logic end_of_message,
    input wire logic wake_up_found,
    input wire logic poll_cfg_b,
    input wire logic freeze_release,
    // FIFO read port
    input wire logic fifo_rd,
    output logic fifo_rd_valid,
    output logic fifo_rd_data,
    // Receiver control
    output logic rf_power_on,
    output logic osc_high_precision,
    output logic startup_req,
    output logic rx_init,
    output logic fsk_mode,
    output logic [4:0] pll_setting,
    output logic id_scan_init,
    output logic fifo_freeze,
    output logic bit_overflow,
    output logic [3:0] state_code,
    // Event pulses
    output logic evt_frame_start,
    output logic evt_valid_id,
    output logic evt_end_of_message
);
    initial begin
        if (DEPTH < 2) begin
            $error("rmf_master_fsm: DEPTH too small");
        end
    end
    typedef struct packed {
        rmf_state_t st;
        logic freeze;
        logic rf_on;
        logic osc_hp;
        logic startup;
        logic init;
        logic fsk;
        logic [4:0] pll;
        logic id_init;
        logic ovf;
        logic ev_fs;
        logic ev_id;
        logic ev_eom;
        logic fclr;
        logic rvalid;
        logic rdata;
    } rmf_st_t;
    rmf_st_t st_ff, nxt_st;
    logic [7:0] chip_mode_control_0, chip_mode_control_1;
    logic mode_poll, slave_receiver_on, dual_config_enable, slave_config_pick, hold_req;
    logic init_buffer_on_init, clear_buffer_at_frame, msg_ident_scan_enable, lock_enable;
    logic store_phase, fifo_in_ready, fifo_out_valid, fifo_out_data, fifo_pop, cfg_b;
    rmf_regs u_regs (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(reg_wr_en),
        .wr_addr(reg_wr_addr),
        .wr_data(reg_wr_data),
        .chip_mode_control_0(chip_mode_control_0),
        .chip_mode_control_1(chip_mode_control_1)
    );

    assign mode_poll = chip_mode_control_0[`RMF_BIT_MODE_SEL];
    assign slave_receiver_on = chip_mode_control_0[`RMF_BIT_SLAVE_RX_ON];
    assign dual_config_enable = chip_mode_control_0[`RMF_BIT_DUAL_CFG];
    assign slave_config_pick = chip_mode_control_0[`RMF_BIT_CFG_PICK];
    assign hold_req = chip_mode_control_1[`RMF_BIT_HOLD];
    assign init_buffer_on_init = rx_ctrl[`RMF_BIT_INIT_BUF];
    assign clear_buffer_at_frame = rx_ctrl[`RMF_BIT_CLR_AT_FRAME];
    assign msg_ident_scan_enable = rx_ctrl[`RMF_BIT_ID_SCAN_EN];
    assign lock_enable = rx_ctrl[`RMF_BIT_LOCK_EN];
    // Slave picks by control bit; polling uses A, or B when dual enabled and poll_cfg_b is set
    assign cfg_b = mode_poll ? (dual_config_enable && poll_cfg_b)
                             : slave_config_pick;

    // Bits are stored from frame start (polling: from wake-up) to END_OF_MESSAGE, only while in sync, never while locked
    assign store_phase = (st_ff.st == ST_FRAME_CLR) || (st_ff.st == ST_ID_SETUP)
        || (st_ff.st == ST_ID_INIT) || (st_ff.st == ST_ID_WAIT)
        || (st_ff.st == ST_ID_CHECK) || (st_ff.st == ST_EOM_CHECK)
        || (st_ff.st == ST_POLL_RUN);
    assign fifo_pop = fifo_rd && fifo_out_valid && !st_ff.rvalid;

    rmf_fifo #(
        .WIDTH(1),
        .DEPTH(DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .clr(st_ff.fclr),
        .in_valid(bit_valid && store_phase && sym_sync),
        .in_data(bit_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_pop),
        .level()
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.startup = 1'b0;
        nxt_st.init = 1'b0;
        nxt_st.id_init = 1'b0;
        nxt_st.ev_fs = 1'b0;
        nxt_st.ev_id = 1'b0;
        nxt_st.ev_eom = 1'b0;
        nxt_st.fclr = 1'b0;
        nxt_st.rvalid = 1'b0;
        nxt_st.ovf = 1'b0;
        if (fifo_pop) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = fifo_out_data;
        end
        if (bit_valid && store_phase && sym_sync && !fifo_in_ready) begin
            nxt_st.ovf = 1'b1;
        end
        if (freeze_release) begin
            nxt_st.freeze = 1'b0;
        end
        case (st_ff.st)
            ST_SLEEP: begin
                nxt_st.rf_on = 1'b0;
                nxt_st.osc_hp = 1'b0;
                if (mode_poll || slave_receiver_on) begin
                    nxt_st.st = ST_STARTUP;
                    nxt_st.startup = 1'b1;
                    nxt_st.rf_on = 1'b1;
                    nxt_st.osc_hp = 1'b1;
                end
            end
            ST_STARTUP: begin
                if (powerup_done) begin
                    nxt_st.st = ST_INIT;
                end
            end
            ST_INIT: begin
                nxt_st.init = 1'b1;
                nxt_st.fclr = init_buffer_on_init;
                nxt_st.fsk = cfg_b ? modulation_type_cfg_b[0]
                                   : modulation_type_cfg_a[0];
                nxt_st.pll = cfg_b ? channel_one_pll_setting_b
                                   : channel_one_pll_setting_a;
                nxt_st.st = mode_poll ? ST_POLL_SEARCH : ST_SYM_WAIT;
            end
            ST_LOCKED: begin
                if (!st_ff.freeze) begin
                    nxt_st.st = ST_SYM_WAIT;
                end
            end
            ST_SYM_WAIT: begin
                if (sym_sync) begin
                    nxt_st.st = ST_FRAME_WAIT;
                end
            end
            ST_FRAME_WAIT: begin
                if (frame_start_event) begin
                    nxt_st.st = ST_FRAME_CLR;
                    nxt_st.ev_fs = 1'b1;
                end
            end
            ST_FRAME_CLR: begin
                nxt_st.fclr = clear_buffer_at_frame;
                nxt_st.st = ST_ID_SETUP;
            end
            ST_ID_SETUP: begin
                nxt_st.st = msg_ident_scan_enable ? ST_ID_INIT : ST_EOM_CHECK;
            end
            ST_ID_INIT: begin
                nxt_st.id_init = 1'b1;
                nxt_st.st = ST_ID_WAIT;
            end
            ST_ID_WAIT: begin
                if (id_scan_done) begin
                    nxt_st.st = id_scan_valid ? ST_EOM_CHECK : ST_FRAME_WAIT;
                    nxt_st.ev_id = id_scan_valid;
                end
            end
            ST_ID_CHECK: begin
                nxt_st.st = ST_EOM_CHECK;
            end
            ST_EOM_CHECK: begin
                if (end_of_message) begin
                    nxt_st.ev_eom = 1'b1;
                    nxt_st.freeze = lock_enable;
                    nxt_st.st = lock_enable ? ST_LOCKED : ST_SYM_WAIT;
                end
            end
            ST_HOLD: begin
                if (!hold_req) begin
                    nxt_st.st = ST_INIT;
                end
            end
            ST_POLL_SEARCH: begin
                if (wake_up_found) begin
                    nxt_st.st = ST_POLL_RUN;
                    nxt_st.fsk = cfg_b ? modulation_type_cfg_b[1]
                                       : modulation_type_cfg_a[1];
                end
            end
            ST_POLL_RUN: begin
                if (end_of_message) begin
                    nxt_st.ev_eom = 1'b1;
                    nxt_st.st = ST_POLL_SEARCH;
                end
            end
            default: begin
                nxt_st.st = ST_SLEEP;
            end
        endcase
        if (st_ff.st != ST_SLEEP && st_ff.st != ST_STARTUP && st_ff.st != ST_INIT) begin
            if (!mode_poll && !slave_receiver_on) begin
                nxt_st.st = ST_SLEEP;
                nxt_st.freeze = 1'b0;
                nxt_st.rf_on = 1'b0;
                nxt_st.osc_hp = 1'b0;
            end else if (!mode_poll && hold_req && st_ff.st != ST_HOLD
                         && st_ff.st != ST_POLL_SEARCH && st_ff.st != ST_POLL_RUN) begin
                nxt_st.st = ST_HOLD;
            end else if (!sym_sync && st_ff.st != ST_LOCKED && st_ff.st != ST_HOLD
                         && st_ff.st != ST_SYM_WAIT && !mode_poll) begin
                nxt_st.st = ST_SYM_WAIT;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{st: ST_SLEEP, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fifo_rd_valid = st_ff.rvalid;
    assign fifo_rd_data = st_ff.rdata;
    assign rf_power_on = st_ff.rf_on;
    assign osc_high_precision = st_ff.osc_hp;
    assign startup_req = st_ff.startup;
    assign rx_init = st_ff.init;
    assign fsk_mode = st_ff.fsk;
    assign pll_setting = st_ff.pll;
    assign id_scan_init = st_ff.id_init;
    assign fifo_freeze = st_ff.freeze;
    assign bit_overflow = st_ff.ovf;
    assign state_code = st_ff.st;
    assign evt_frame_start = st_ff.ev_fs;
    assign evt_valid_id = st_ff.ev_id;
    assign evt_end_of_message = st_ff.ev_eom;
endmodule
`default_nettype wire

// ==== inc/rmf_cfg.svh ====
`ifndef RMF_CFG_SVH
`define RMF_CFG_SVH
`define RMF_ADDR_CHIP_MODE_CONTROL_0 8'h02
`define RMF_ADDR_CHIP_MODE_CONTROL_1 8'h03
`define RMF_RST_CHIP_MODE_CONTROL_0 8'h40
`define RMF_RST_CHIP_MODE_CONTROL_1 8'h00
`define RMF_BIT_MODE_SEL 0
`define RMF_BIT_SLAVE_RX_ON 1
`define RMF_BIT_DUAL_CFG 2
`define RMF_BIT_CFG_PICK 3
`define RMF_BIT_HOLD 6
`define RMF_BIT_INIT_BUF 0
`define RMF_BIT_CLR_AT_FRAME 1
`define RMF_BIT_ID_SCAN_EN 2
`define RMF_BIT_LOCK_EN 3
`endif

// ==== inc/rmf_pkg.sv ====
package rmf_pkg;
    typedef enum logic [3:0] {
        ST_SLEEP,
        ST_STARTUP,
        ST_INIT,
        ST_LOCKED,
        ST_SYM_WAIT,
        ST_FRAME_WAIT,
        ST_FRAME_CLR,
        ST_ID_SETUP,
        ST_ID_INIT,
        ST_ID_WAIT,
        ST_ID_CHECK,
        ST_EOM_CHECK,
        ST_HOLD,
        ST_POLL_SEARCH,
        ST_POLL_RUN
    } rmf_state_t;
endpackage

// ==== core/rmf_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmf_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clr,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("rmf_fifo: DEPTH must be a power of two >= 2");
        end
    end
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } rmf_fifo_st_t;
    rmf_fifo_st_t st_ff, nxt_st;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic do_wr, do_rd;
    assign level = st_ff.wr - st_ff.rd;
    assign in_ready = (level != (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem_ff[st_ff.rd[AW-1:0]];
    assign do_wr = in_valid && in_ready && !clr;
    assign do_rd = out_valid && out_ready && !clr;
    always_comb begin
        nxt_st = st_ff;
        if (clr) begin
            nxt_st = '0;
        end else begin
            if (do_wr) begin
                nxt_st.wr = st_ff.wr + 1'b1;
            end
            if (do_rd) begin
                nxt_st.rd = st_ff.rd + 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem_ff[st_ff.wr[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ==== core/rmf_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rmf_cfg.svh"
module rmf_regs
    import rmf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register write port
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Register contents
    output logic [7:0] chip_mode_control_0,
    output logic [7:0] chip_mode_control_1
);
    typedef struct packed {
        logic [7:0] c0;
        logic [7:0] c1;
    } rmf_regs_st_t;
    rmf_regs_st_t st_ff, nxt_st;
    assign chip_mode_control_0 = st_ff.c0;
    assign chip_mode_control_1 = st_ff.c1;
    always_comb begin
        nxt_st = st_ff;
        if (wr_en && wr_addr == `RMF_ADDR_CHIP_MODE_CONTROL_0) begin
            nxt_st.c0 = wr_data;
        end
        if (wr_en && wr_addr == `RMF_ADDR_CHIP_MODE_CONTROL_1) begin
            nxt_st.c1 = wr_data;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff <= {`RMF_RST_CHIP_MODE_CONTROL_0, `RMF_RST_CHIP_MODE_CONTROL_1};
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

// ==== tb/rmf_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmf_chk
    import rmf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Inputs watched
    input wire logic [3:0] rx_ctrl,
    input wire logic powerup_done,
    input wire logic sym_sync,
    input wire logic end_of_message,
    input wire logic id_scan_done,
    input wire logic id_scan_valid,
    input wire logic freeze_release,
    // Outputs watched
    input wire logic [3:0] state_code,
    input wire logic fifo_freeze,
    input wire logic rf_power_on,
    input wire logic osc_high_precision
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // End of message seen while the stream is in sync
    sequence s_eom;
        state_code == 4'hB && end_of_message && sym_sync;
    endsequence
    // Sleep left on this edge
    sequence s_leave_sleep;
        state_code == 4'h0 ##1 state_code != 4'h0;
    endsequence
    chk_startup_wait: assert property (state_code == 4'h1 && !powerup_done
        |=> state_code == 4'h1) else $error("start-up left before power-up");
    chk_locked_stays: assert property (state_code == 4'h3 && fifo_freeze && !freeze_release
        |=> state_code inside {4'h3, 4'h0, 4'hC}) else $error("locked state left");
    chk_sync_loss: assert property (state_code inside {[4'h4:4'hB]} && !sym_sync
        |=> state_code inside {4'h4, 4'h0, 4'hC}) else $error("sync loss ignored");
    chk_scan_skip: assert property (state_code == 4'h7 && sym_sync && !rx_ctrl[2]
        |=> state_code inside {4'hB, 4'h0, 4'hC}) else $error("scan not skipped");
    chk_bad_id: assert property (state_code == 4'h9 && id_scan_done && !id_scan_valid
        && sym_sync |-> ##[1:2] state_code inside {4'h5, 4'h0, 4'hC})
        else $error("no frame restart");
    chk_eom_lock: assert property (s_eom ##0 rx_ctrl[3]
        |-> ##[1:2] (state_code == 4'h3 && fifo_freeze) || state_code inside {4'h0, 4'hC})
        else $error("no lock at end");
    chk_eom_free: assert property (s_eom ##0 !rx_ctrl[3]
        |-> ##[1:2] state_code inside {4'h4, 4'h0, 4'hC}) else $error("no sync wait at end");
    chk_hold_exit: assert property (state_code == 4'hC
        |=> state_code inside {4'hC, 4'h2, 4'h0}) else $error("hold left wrongly");
    chk_sleep_off: assert property (state_code == 4'h0 && $past(state_code) == 4'h0
        |-> !rf_power_on && !osc_high_precision) else $error("power on in sleep");
    chk_wake_start: assert property (s_leave_sleep
        |-> state_code inside {4'h1, 4'hD}) else $error("sleep exit skips start-up");
endmodule
bind rmf_master_fsm rmf_chk u_chk (
    .sys_clk(sys_clk), .rst(rst), .rx_ctrl(rx_ctrl), .powerup_done(powerup_done),
    .sym_sync(sym_sync), .end_of_message(end_of_message), .id_scan_done(id_scan_done),
    .id_scan_valid(id_scan_valid), .freeze_release(freeze_release), .state_code(state_code),
    .fifo_freeze(fifo_freeze), .rf_power_on(rf_power_on),
    .osc_high_precision(osc_high_precision)
);
`default_nettype wire

// ==== tb/rmf_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmf_host (
    // Clock
    input wire logic sys_clk,
    // Register writes
    output logic reg_wr_en,
    output logic [7:0] reg_wr_addr,
    output logic [7:0] reg_wr_data,
    // FIFO reads
    output logic fifo_rd,
    input wire logic fifo_rd_valid,
    input wire logic fifo_rd_data
);
    initial begin
        reg_wr_en = 1'b0;
        reg_wr_addr = 8'h00;
        reg_wr_data = 8'h00;
        fifo_rd = 1'b0;
    end
    // One write cycle; the idle bus shows a fresh pattern
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        @(negedge sys_clk);
        reg_wr_en = 1'b1;
        reg_wr_addr = a;
        reg_wr_data = dt;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_wr_addr = ~a;
        reg_wr_data = ~dt;
    endtask
    // Reconfigure during hold, then settle before release
    task automatic reinit(input logic [7:0] c0);
        wr(8'h02, c0);
        repeat (4000) @(negedge sys_clk);
        wr(8'h03, 8'h00);
    endtask
    task automatic rd(output logic v, output logic dt);
        @(negedge sys_clk);
        fifo_rd = 1'b1;
        @(negedge sys_clk);
        fifo_rd = 1'b0;
        v = 1'b0;
        dt = 1'b0;
        for (int i = 0; i < 3 && !v; i++) begin
            if (fifo_rd_valid === 1'b1) begin
                v = 1'b1;
                dt = fifo_rd_data;
            end else begin
                @(negedge sys_clk);
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/rmf_master_fsm_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmf_master_fsm_tb_top;
    logic sys_clk, rst, reg_wr_en, powerup_done, sym_sync, frame_start_event, bit_valid;
    logic bit_data, id_scan_done, id_scan_valid, end_of_message, wake_up_found, poll_cfg_b;
    logic freeze_release, fifo_rd, fifo_rd_valid, fifo_rd_data, rf_power_on, startup_req;
    logic osc_high_precision, rx_init, fsk_mode, id_scan_init, fifo_freeze, bit_overflow;
    logic evt_frame_start, evt_valid_id, evt_end_of_message, v, d;
    logic [7:0] reg_wr_addr, reg_wr_data;
    logic [3:0] rx_ctrl, state_code;
    logic [1:0] modulation_type_cfg_a, modulation_type_cfg_b;
    logic [4:0] channel_one_pll_setting_a, channel_one_pll_setting_b, pll_setting;
    int err_count = 0;
    int check_count = 0;
    int seed = 10668;
    int cyc = 0;
    int ev_fs = 0, ev_id = 0, ev_eom = 0, ev_ovf = 0;
    int ev_su = 0, ev_ini = 0, ev_idi = 0;
    logic exp_q[$];
    rmf_master_fsm #(.DEPTH(32)) DUT (
        .sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .rx_ctrl(rx_ctrl),
        .modulation_type_cfg_a(modulation_type_cfg_a),
        .modulation_type_cfg_b(modulation_type_cfg_b),
        .channel_one_pll_setting_a(channel_one_pll_setting_a),
        .channel_one_pll_setting_b(channel_one_pll_setting_b),
        .powerup_done(powerup_done), .sym_sync(sym_sync), .frame_start_event(frame_start_event),
        .bit_valid(bit_valid), .bit_data(bit_data), .id_scan_done(id_scan_done),
        .id_scan_valid(id_scan_valid), .end_of_message(end_of_message),
        .wake_up_found(wake_up_found), .poll_cfg_b(poll_cfg_b), .freeze_release(freeze_release),
        .fifo_rd(fifo_rd), .fifo_rd_valid(fifo_rd_valid), .fifo_rd_data(fifo_rd_data),
        .rf_power_on(rf_power_on), .osc_high_precision(osc_high_precision),
        .startup_req(startup_req), .rx_init(rx_init), .fsk_mode(fsk_mode),
        .pll_setting(pll_setting), .id_scan_init(id_scan_init), .fifo_freeze(fifo_freeze),
        .bit_overflow(bit_overflow), .state_code(state_code),
        .evt_frame_start(evt_frame_start), .evt_valid_id(evt_valid_id),
        .evt_end_of_message(evt_end_of_message)
    );
    rmf_host host (
        .sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .fifo_rd(fifo_rd), .fifo_rd_valid(fifo_rd_valid),
        .fifo_rd_data(fifo_rd_data)
    );
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        ev_fs += int'(evt_frame_start === 1'b1);
        ev_id += int'(evt_valid_id === 1'b1);
        ev_eom += int'(evt_end_of_message === 1'b1);
        ev_ovf += int'(bit_overflow === 1'b1);
        ev_su += int'(startup_req === 1'b1);
        ev_ini += int'(rx_init === 1'b1);
        ev_idi += int'(id_scan_init === 1'b1);
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    function automatic logic [4:0] exp_pll(input logic pick);
        return pick ? channel_one_pll_setting_b : channel_one_pll_setting_a;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask
    task automatic wait_st(input logic [3:0] s);
        for (int i = 0; i < 60 && state_code !== s; i++) @(negedge sys_clk);
    endtask
    task automatic send(input int n);
        logic b;
        for (int i = 0; i < n; i++) begin
            b = 1'($random(seed));
            exp_q.push_back(b);
            bit_data = b;
            pulse(bit_valid);
        end
    endtask
    task automatic drain(input int n);
        for (int i = 0; i < n; i++) begin
            host.rd(v, d);
            chk("fifo_rd_valid", 8'h01, 8'(v));
            chk("fifo_rd_data", 8'(exp_q.pop_front()), 8'(d));
        end
    endtask
    task automatic frame(input logic idv, input int n);
        pulse(frame_start_event);
        wait_st(rx_ctrl[2] ? 4'h9 : 4'hB);
        send(n);
        if (rx_ctrl[2]) begin
            id_scan_valid = idv;
            pulse(id_scan_done);
            if (!idv) return;
            wait_st(4'hB);
            send(n);
        end
        pulse(end_of_message);
    endtask
    task automatic empty_chk();
        host.rd(v, d);
        chk("fifo_empty", 8'h00, 8'(v));
    endtask
    initial begin
        rst = 1'b1;
        {powerup_done, sym_sync, frame_start_event, bit_valid, bit_data} = 5'h00;
        {id_scan_done, id_scan_valid, end_of_message, wake_up_found, poll_cfg_b} = 5'h00;
        freeze_release = 1'b0;
        rx_ctrl = 4'h1;
        modulation_type_cfg_a = 2'h2;
        modulation_type_cfg_b = 2'h1;
        channel_one_pll_setting_a = 5'($random(seed));
        channel_one_pll_setting_b = ~channel_one_pll_setting_a;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        host.wr(8'h04, 8'hFF);
        wait_st(4'h1);
        chk("state_code", 8'h00, 8'(state_code));
        host.wr(8'h02, 8'h02);
        wait_st(4'h1);
        repeat (5) @(negedge sys_clk);
        chk("state_code", 8'h01, 8'(state_code));
        chk("rf_power_on", 8'h01, 8'(rf_power_on));
        chk("osc_high_precision", 8'h01, 8'(osc_high_precision));
        powerup_done = 1'b1;
        wait_st(4'h4);
        chk("state_code", 8'h04, 8'(state_code));
        chk("pll_setting", 8'(exp_pll(1'b0)), 8'(pll_setting));
        chk("fsk_mode", 8'(modulation_type_cfg_a[0]), 8'(fsk_mode));
        sym_sync = 1'b1;
        frame(1'b1, 8);
        drain(8);
        rx_ctrl = 4'hC;
        frame(1'b0, 5);
        wait_st(4'h5);
        chk("state_code", 8'h05, 8'(state_code));
        frame(1'b1, 3);
        wait_st(4'h3);
        chk("fifo_freeze", 8'h01, 8'(fifo_freeze));
        pulse(frame_start_event);
        chk("state_code", 8'h03, 8'(state_code));
        pulse(freeze_release);
        wait_st(4'h5);
        drain(11);
        rx_ctrl = 4'h2;
        frame(1'b1, 4);
        exp_q.delete();
        frame(1'b1, 3);
        drain(3);
        empty_chk();
        rx_ctrl = 4'h0;
        frame(1'b1, 33);
        void'(exp_q.pop_back());
        drain(32);
        empty_chk();
        pulse(frame_start_event);
        wait_st(4'hB);
        sym_sync = 1'b0;
        wait_st(4'h4);
        repeat (3) @(negedge sys_clk);
        chk("state_code", 8'h04, 8'(state_code));
        sym_sync = 1'b1;
        wait_st(4'h5);
        chk("state_code", 8'h05, 8'(state_code));
        rx_ctrl = 4'h1;
        frame(1'b1, 2);
        host.wr(8'h03, 8'h40);
        wait_st(4'hC);
        chk("state_code", 8'h0C, 8'(state_code));
        host.reinit(8'h0A);
        wait_st(4'h5);
        chk("pll_setting", 8'(exp_pll(1'b1)), 8'(pll_setting));
        chk("fsk_mode", 8'(modulation_type_cfg_b[0]), 8'(fsk_mode));
        empty_chk();
        chk("ev_fs", 8'h08, 8'(ev_fs));
        chk("ev_id", 8'h01, 8'(ev_id));
        chk("ev_eom", 8'h06, 8'(ev_eom));
        chk("ev_ovf", 8'h01, 8'(ev_ovf));
        chk("ev_su", 8'h01, 8'(ev_su));
        chk("ev_ini", 8'h02, 8'(ev_ini));
        chk("ev_idi", 8'h02, 8'(ev_idi));
        host.wr(8'h02, 8'h00);
        wait_st(4'h0);
        repeat (2) @(negedge sys_clk);
        chk("power", 8'h00, 8'({rf_power_on, osc_high_precision}));
        host.wr(8'h02, 8'h05);
        wait_st(4'hD);
        chk("state_code", 8'h0D, 8'(state_code));
        pulse(wake_up_found);
        wait_st(4'hE);
        chk("state_code", 8'h0E, 8'(state_code));
        chk("fsk_mode", 8'(modulation_type_cfg_a[1]), 8'(fsk_mode));
        poll_cfg_b = 1'b1;
        pulse(end_of_message);
        wait_st(4'hD);
        pulse(wake_up_found);
        wait_st(4'hE);
        chk("fsk_mode", 8'(modulation_type_cfg_b[1]), 8'(fsk_mode));
        chk("ev_su", 8'h02, 8'(ev_su));
        chk("ev_ini", 8'h03, 8'(ev_ini));
        final_report();
    end
endmodule
`default_nettype wire
